// *** core/dcs_channel.v ***
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dcs_defines.vh"

module dcs_channel (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // register port
  input wire [`DCS_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_wide,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // transfer engine side
  input wire count_zero,
  input wire dev_done,
  input wire xfer_error,
  input wire [`DCS_FAULT_W-1:0] xfer_error_code,
  input wire other_ctl_write,
  output reg start_pulse,
  output reg channel_running_flag,
  output reg halt_request,
  output reg continue_pending,
  output wire block_advance,
  output wire terminate,
  // peripheral and interrupt
  input wire periph_control_line,
  output wire interrupt_request_out
);

  // command register state
  reg start_request;
  reg software_abort;
  reg int_enable;

  // status register flags
  reg operation_complete_flag;
  reg block_done_flag;
  reg device_terminated_flag;
  reg err_flag;
  reg periph_line_fall_flag;

  // fault code and device control
  reg [`DCS_FAULT_W-1:0] fault_code;
  reg [7:0] dev_ctl;

  wire periph_line_level;
  wire line_fall;

  dcs_line_sync u_line_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pin(periph_control_line),
    .level(periph_line_level),
    .fall(line_fall)
  );

  // decode
  wire wr_cmd = reg_wr && (reg_addr == `DCS_OFF_CMD);
  wire wr_state = reg_wr && (reg_addr == `DCS_OFF_STATE);
  wire wr_devctl = reg_wr && (reg_addr == `DCS_OFF_DEVCTL);
  wire wr_start = wr_cmd && reg_wdata[`DCS_CMD_START];
  wire wr_cont = wr_cmd && reg_wdata[`DCS_CMD_CONT];
  wire wr_abort = wr_cmd && reg_wdata[`DCS_CMD_ABORT];

  wire [1:0] dev_type = dev_ctl[`DCS_DC_TYPE_HI:`DCS_DC_TYPE_LO];
  wire [2:0] line_func = dev_ctl[`DCS_DC_LINE_HI:`DCS_DC_LINE_LO];
  // with ack and ready the line is the ready input, so its status is dropped
  wire line_used = (dev_type != `DCS_TYPE_ACK_RDY);

  // start faults; continue is sampled before this write lands
  wire start_fault = wr_start && (continue_pending
    || reg_wide
    || channel_running_flag);
  // any other control register touched while running
  wire ctl_fault = channel_running_flag && (wr_devctl || other_ctl_write);
  wire timing_fault = start_fault || ctl_fault;
  wire launch = wr_start && !start_fault;

  // terminations of a running channel
  wire ext_abort = channel_running_flag && line_used && line_fall
    && (line_func == `DCS_LINE_ABORT);
  wire sw_abort = channel_running_flag && (wr_abort || software_abort);
  wire run_error = channel_running_flag && xfer_error;
  wire count_end = channel_running_flag && count_zero;

  // a new fault code, if any, in priority order
  reg any_fault;
  reg [`DCS_FAULT_W-1:0] new_code;
  always @* begin
    any_fault = 1'b1;
    new_code = `DCS_FAULT_NONE;
    if (timing_fault) begin
      new_code = `DCS_FAULT_TIMING;
    end else if (run_error) begin
      new_code = xfer_error_code;
    end else if (sw_abort) begin
      new_code = `DCS_FAULT_SW_ABORT;
    end else if (ext_abort) begin
      new_code = `DCS_FAULT_EXT_ABORT;
    end else begin
      any_fault = 1'b0;
    end
  end

  // a refused start while running is a timing error that ends the run as well
  wire fault_stop = channel_running_flag && (timing_fault || run_error || sw_abort || ext_abort);
  assign block_advance = count_end && continue_pending && !fault_stop;
  wire normal_end = (count_end && !continue_pending) || (channel_running_flag && dev_done);
  assign terminate = fault_stop || normal_end;
  // a refused start is an error termination of its own
  wire complete_evt = terminate || start_fault;

  // command register
  always @(posedge core_clk) begin
    if (!nrst) begin
      start_request <= 1'b0;
      continue_pending <= 1'b0;
      halt_request <= 1'b0;
      software_abort <= 1'b0;
      int_enable <= 1'b0;
      start_pulse <= 1'b0;
    end else begin
      // the start bit lives for one clock only
      start_request <= wr_start;
      start_pulse <= launch;
      if (wr_cmd) begin
        halt_request <= reg_wdata[`DCS_CMD_HALT];
        int_enable <= reg_wdata[`DCS_CMD_IEN];
      end
      if (wr_cmd && reg_wdata[`DCS_CMD_ABORT]) begin
        software_abort <= 1'b1;
      end else if (launch) begin
        software_abort <= 1'b0;
      end
      // a write of one sets continue; a write of zero leaves it alone
      if (wr_cont) begin
        continue_pending <= 1'b1;
      end else if (count_end || fault_stop) begin
        continue_pending <= 1'b0;
      end
    end
  end

  // run state
  always @(posedge core_clk) begin
    if (!nrst) begin
      channel_running_flag <= 1'b0;
    end else if (launch) begin
      channel_running_flag <= 1'b1;
    end else if (terminate) begin
      channel_running_flag <= 1'b0;
    end
  end

  // status flags: a setting event wins over a clearing write in the same cycle
  wire [7:0] clr = wr_state ? reg_wdata : `DCS_ZERO8;
  wire err_evt = any_fault;
  wire fall_evt = line_fall && line_used;

  always @(posedge core_clk) begin
    if (!nrst) begin
      operation_complete_flag <= 1'b0;
      block_done_flag <= 1'b0;
      device_terminated_flag <= 1'b0;
      err_flag <= 1'b0;
      periph_line_fall_flag <= 1'b0;
    end else begin
      operation_complete_flag <= complete_evt
        || (operation_complete_flag && !clr[`DCS_ST_COMPLETE]);
      block_done_flag <= block_advance
        || (block_done_flag && !clr[`DCS_ST_BLOCK]);
      device_terminated_flag <= (channel_running_flag && dev_done && !fault_stop)
        || (device_terminated_flag && !clr[`DCS_ST_DEVTERM]);
      err_flag <= err_evt || (err_flag && !clr[`DCS_ST_ERR]);
      periph_line_fall_flag <= fall_evt
        || (periph_line_fall_flag && !clr[`DCS_ST_FALL]);
    end
  end

  // fault code: first one since the flag was cleared
  always @(posedge core_clk) begin
    if (!nrst) begin
      fault_code <= `DCS_FAULT_NONE;
    end else if (err_evt && (!err_flag || clr[`DCS_ST_ERR])) begin
      fault_code <= new_code;
    end else if (clr[`DCS_ST_ERR]) begin
      fault_code <= `DCS_FAULT_NONE;
    end
  end

  // device control; a write while running is refused and flagged
  always @(posedge core_clk) begin
    if (!nrst) begin
      dev_ctl <= `DCS_ZERO8;
    end else if (wr_devctl && !channel_running_flag) begin
      dev_ctl <= reg_wdata & `DCS_DC_MASK;
    end
  end

  // interrupt request
  wire line_irq = periph_line_fall_flag && line_used
    && (line_func == `DCS_LINE_STAT_IRQ);
  assign interrupt_request_out = int_enable
    && (operation_complete_flag || block_done_flag || line_irq);

  // read assembly
  reg [7:0] cmd_view;
  reg [7:0] state_view;
  always @* begin
    cmd_view = `DCS_ZERO8;
    cmd_view[`DCS_CMD_START] = 1'b0;
    cmd_view[`DCS_CMD_CONT] = continue_pending;
    cmd_view[`DCS_CMD_HALT] = halt_request;
    cmd_view[`DCS_CMD_ABORT] = software_abort;
    cmd_view[`DCS_CMD_IEN] = int_enable;
    state_view = `DCS_ZERO8;
    state_view[`DCS_ST_COMPLETE] = operation_complete_flag;
    state_view[`DCS_ST_BLOCK] = block_done_flag;
    state_view[`DCS_ST_DEVTERM] = device_terminated_flag;
    state_view[`DCS_ST_ERR] = err_flag;
    state_view[`DCS_ST_ACTIVE] = channel_running_flag;
    state_view[`DCS_ST_FALL] = periph_line_fall_flag && line_used;
    state_view[`DCS_ST_LEVEL] = periph_line_level && line_used;
  end

  // read data stand for the one cycle after the strobe
  always @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata <= `DCS_ZERO8;
    end else if (reg_rd) begin
      case (reg_addr)
        `DCS_OFF_CMD: reg_rdata <= cmd_view;
        `DCS_OFF_STATE: reg_rdata <= state_view;
        `DCS_OFF_FAULT: reg_rdata <= {3'h0, fault_code};
        `DCS_OFF_DEVCTL: reg_rdata <= dev_ctl;
        default: reg_rdata <= `DCS_ZERO8;
      endcase
    end else begin
      reg_rdata <= `DCS_ZERO8;
    end
  end

endmodule // dcs_channel

`default_nettype wire

// *** shared/dcs_defines.vh ***
`ifndef DCS_DEFINES_VH
`define DCS_DEFINES_VH

// register offsets on the local port
`define DCS_ADDR_W 3
`define DCS_OFF_STATE 3'h0
`define DCS_OFF_FAULT 3'h1
`define DCS_OFF_DEVCTL 3'h4
`define DCS_OFF_CMD 3'h7

// command register fields
`define DCS_CMD_START 7
`define DCS_CMD_CONT 6
`define DCS_CMD_HALT 5
`define DCS_CMD_ABORT 4
`define DCS_CMD_IEN 3

// status register fields
`define DCS_ST_COMPLETE 7
`define DCS_ST_BLOCK 6
`define DCS_ST_DEVTERM 5
`define DCS_ST_ERR 4
`define DCS_ST_ACTIVE 3
`define DCS_ST_FALL 1
`define DCS_ST_LEVEL 0

// device control fields
`define DCS_DC_TYPE_HI 5
`define DCS_DC_TYPE_LO 4
`define DCS_DC_LINE_HI 2
`define DCS_DC_LINE_LO 0
`define DCS_DC_MASK 8'h37

// device type and line function codes
`define DCS_TYPE_ACK_RDY 2'h3
`define DCS_LINE_STAT_IRQ 3'h1
`define DCS_LINE_ABORT 3'h3

// fault codes
`define DCS_FAULT_W 5
`define DCS_FAULT_NONE 5'h00
`define DCS_FAULT_TIMING 5'h02
`define DCS_FAULT_EXT_ABORT 5'h10
`define DCS_FAULT_SW_ABORT 5'h11

`define DCS_ZERO8 8'h00

`endif

// *** core/dcs_line_sync.v ***
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser; the level moves only once stages two and three agree
module dcs_line_sync (
  // clock and reset
  input wire core_clk,
  input wire nrst,
  // pin side
  input wire pin,
  // core side
  output reg level,
  output reg fall
);

  reg s1;
  reg s2;
  reg s3;

  always @(posedge core_clk) begin
    if (!nrst) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      level <= 1'b1;
      fall <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      fall <= 1'b0;
      if (s2 == s3) begin
        level <= s3;
        fall <= level & ~s3;
      end
    end
  end

endmodule // dcs_line_sync

`default_nettype wire

// *** bench/dcs_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dcs_far_model (
  // clock
  input wire logic core_clk,
  // engine and peripheral side
  output logic count_zero,
  output logic dev_done,
  output logic xfer_error,
  output logic [4:0] xfer_error_code,
  output logic other_ctl_write,
  output logic periph_control_line
);
  logic [4:0] code = 5'h00;
  logic [4:0] cyc = 5'h00;
  // code bus churns outside an error pulse so a stale code cannot pass
  assign xfer_error_code = xfer_error ? code : cyc;
  always @(posedge core_clk) cyc <= cyc + 5'h01;
  initial begin
    {count_zero, dev_done, xfer_error, other_ctl_write} = 4'h0;
    periph_control_line = 1'b1;
  end
  task automatic ev(input logic [3:0] m, input logic [4:0] c);
    @(posedge core_clk);
    {count_zero, dev_done, xfer_error, other_ctl_write} <= m;
    code <= c;
    @(posedge core_clk);
    {count_zero, dev_done, xfer_error, other_ctl_write} <= 4'h0;
  endtask
  // six cycles covers the pin synchroniser
  task automatic ln(input logic v);
    @(posedge core_clk);
    periph_control_line <= v;
    repeat (6) @(posedge core_clk);
  endtask
endmodule // dcs_far_model
`default_nettype wire

// *** bench/dcs_channel_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dcs_defines.vh"
module dcs_channel_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [`DCS_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_wide,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // engine side
  input wire logic count_zero,
  input wire logic dev_done,
  input wire logic xfer_error,
  input wire logic [`DCS_FAULT_W-1:0] xfer_error_code,
  input wire logic other_ctl_write,
  input wire logic start_pulse,
  input wire logic channel_running_flag,
  input wire logic halt_request,
  input wire logic continue_pending,
  input wire logic block_advance,
  input wire logic terminate,
  // peripheral
  input wire logic periph_control_line,
  input wire logic interrupt_request_out
);
  wire wcmd = reg_wr && reg_addr == `DCS_OFF_CMD;
  wire st = wcmd && reg_wdata[`DCS_CMD_START];
  wire cz = count_zero && channel_running_flag && continue_pending;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_start;
    st && !reg_wide && !continue_pending && !channel_running_flag
      |=> start_pulse && channel_running_flag ##1 !start_pulse;
  endproperty
  a_start: assert property (p_start) else $error("start not launched");
  property p_wide; st && reg_wide |=> !start_pulse; endproperty
  a_wide: assert property (p_wide) else $error("wide start launched");
  property p_cont; st && continue_pending |=> !start_pulse; endproperty
  a_cont: assert property (p_cont) else $error("start with continue launched");
  property p_blk;
    cz && !xfer_error && !other_ctl_write && !wcmd |-> block_advance && !terminate;
  endproperty
  a_blk: assert property (p_blk) else $error("no block advance");
  property p_cclr; cz && !wcmd |=> !continue_pending; endproperty
  a_cclr: assert property (p_cclr) else $error("continue kept");
  property p_term; terminate |=> !channel_running_flag; endproperty
  a_term: assert property (p_term) else $error("active after end");
  property p_oth; other_ctl_write && channel_running_flag |-> terminate; endproperty
  a_oth: assert property (p_oth) else $error("control write while running");
  property p_abort;
    wcmd && reg_wdata[`DCS_CMD_ABORT] && !reg_wdata[7] && channel_running_flag
      |-> ##[0:1] !channel_running_flag;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_halt;
    wcmd && !reg_wdata[7] |=> halt_request == $past(reg_wdata[`DCS_CMD_HALT]);
  endproperty
  a_halt: assert property (p_halt) else $error("halt not stored");
  property p_cmdrd;
    reg_rd && reg_addr == `DCS_OFF_CMD |=> reg_rdata[7] == 1'b0 && reg_rdata[2:0] == 3'h0;
  endproperty
  a_cmdrd: assert property (p_cmdrd) else $error("command read bits");
  cover property (block_advance);
  cover property (terminate);
  cover property (interrupt_request_out);
endmodule // dcs_channel_chk
bind dcs_channel dcs_channel_chk u_chk (
  .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_wide(reg_wide), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .count_zero(count_zero), .dev_done(dev_done), .xfer_error(xfer_error),
  .xfer_error_code(xfer_error_code), .other_ctl_write(other_ctl_write),
  .start_pulse(start_pulse), .channel_running_flag(channel_running_flag),
  .halt_request(halt_request), .continue_pending(continue_pending),
  .block_advance(block_advance), .terminate(terminate),
  .periph_control_line(periph_control_line),
  .interrupt_request_out(interrupt_request_out));
`default_nettype wire

// *** bench/dcs_channel_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dcs_defines.vh"
module dcs_channel_tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [`DCS_ADDR_W-1:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_wide = 1'b0;
  logic reg_rd = 1'b0;
  wire [7:0] rdata;
  wire [4:0] xc;
  wire cz, dd, xe, oc, pl, halt, irq;
  int err_count = 0;
  int samples_checked = 0;
  dcs_far_model far (.core_clk(core_clk), .count_zero(cz), .dev_done(dd), .xfer_error(xe),
    .xfer_error_code(xc), .other_ctl_write(oc), .periph_control_line(pl));
  dcs_channel dut (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_wide(reg_wide), .reg_rd(reg_rd),
    .reg_rdata(rdata), .count_zero(cz), .dev_done(dd), .xfer_error(xe),
    .xfer_error_code(xc), .other_ctl_write(oc), .start_pulse(), .channel_running_flag(),
    .halt_request(halt), .continue_pending(), .block_advance(), .terminate(),
    .periph_control_line(pl), .interrupt_request_out(irq));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic k(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic w(input logic [2:0] a, input logic [7:0] d, input logic wd = 1'b0);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wide <= wd;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wide <= 1'b0;
  endtask
  // read data is looked at mid-cycle, where it has settled
  task automatic r(input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    k($sformatf("reg%0d", a), e, rdata);
  endtask
  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge core_clk);
    r(0, 8'h01);
    r(1, 8'h00);
    r(7, 8'h00);
    w(7, 8'h88);
    r(0, 8'h09);
    r(7, 8'h08);
    far.ev(4'h8, 5'h00);
    r(0, 8'h81);
    k("irq", 8'h01, {7'h0, irq});
    w(0, 8'h00);
    r(0, 8'h81);
    w(0, 8'h80);
    r(0, 8'h01);
    k("irq", 8'h00, {7'h0, irq});
    w(7, 8'hc0);
    far.ev(4'h8, 5'h00);
    r(0, 8'h49);
    r(7, 8'h00);
    far.ev(4'h4, 5'h00);
    r(0, 8'he1);
    w(0, 8'he0);
    w(7, 8'h80);
    w(7, 8'h20);
    @(negedge core_clk);
    k("halt", 8'h01, {7'h0, halt});
    w(7, 8'h00);
    @(negedge core_clk);
    k("halt", 8'h00, {7'h0, halt});
    w(7, 8'h10);
    r(0, 8'h91);
    r(1, 8'h11);
    w(0, 8'h90);
    r(1, 8'h00);
    w(7, 8'h80);
    far.ev(4'h1, 5'h00);
    r(1, 8'h02);
    w(0, 8'h90);
    w(7, 8'h80, 1'b1);
    r(0, 8'h91);
    w(0, 8'h90);
    w(7, 8'h80);
    far.ev(4'h2, 5'h0d);
    r(1, 8'h0d);
    // a later refused start must not replace the first code
    w(7, 8'h80, 1'b1);
    r(1, 8'h0d);
    w(0, 8'h90);
    // device control touched while running: dropped and flagged
    w(7, 8'h80);
    w(4, 8'h01);
    r(0, 8'h91);
    r(1, 8'h02);
    r(4, 8'h00);
    w(0, 8'h90);
    w(4, 8'h01);
    w(7, 8'h08);
    far.ln(1'b0);
    r(0, 8'h02);
    k("irq", 8'h01, {7'h0, irq});
    far.ln(1'b1);
    w(0, 8'h02);
    r(0, 8'h01);
    w(4, 8'h00);
    far.ln(1'b0);
    r(0, 8'h02);
    k("irq", 8'h00, {7'h0, irq});
    w(4, 8'h30);
    r(0, 8'h00);
    w(4, 8'h00);
    far.ln(1'b1);
    w(0, 8'h02);
    r(3, 8'h00);
    w(7, 8'h40);
    w(7, 8'h80);
    r(0, 8'h91);
    r(1, 8'h02);
    // reset while idle after a refused start, with complete and error flags, code and continue all set
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    r(0, 8'h01);
    r(1, 8'h00);
    r(7, 8'h00);
    print_verdict();
  end
endmodule // dcs_channel_tb_top
`default_nettype wire
